/* pcg_top.sv */
// PLL divider registers, lock timing and per-block clock gating behind APB.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

// Functional notes
// R1 - PLL output is m*Fin/(p*2^s), m = main divider+8, p = pre divider+2.
// R2 - Software keeps 6.48/sqrt(m) strictly between 0.7 and 1.8.
// R3 - PLL fields: main divider [19:12], pre divider [9:4], post divider [1:0].
// R4 - Reset main divider 0x48 main, 0x30 aux; pre 0x02, post 0x1.
// R5 - Software should use the tabulated divider sets for a 12 MHz reference.
// R6 - Gate bit 1 passes its clock, 0 blocks it; reset value 0x03FFFFF0.
// R7 - Bus clock gates at bits 29, 25, 24, 22, 21 and 7.
// R8 - Aux PLL gates at 23 and 4; codec clock gates at 28, 26, 20.
// R9 - Peripheral bus gates at bits 19 down to 8, audio codec at 6.
// R10 - Bit 2 enters IDLE; hardware never clears the bit.
// R11 - Bit 0 enters STOP; hardware never clears it; resets to 0.
// R12 - Bit 1 enables the bus clock monitor output; resets to 0.
// R13 - IDLE ends on any interrupt, warm reset or cold reset.
// R14 - STOP ends on external, RTC alarm or modem interrupt, or reset.
// R15 - After PLL restart wait lock count times 16 reference periods.
// R16 - A divider change holds that PLL's block clocks until lock expires.
module pcg_top
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [31:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // Pins and wake sources
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_warm_reset_pin_n,
  input  wire logic                 i_irq_any,
  input  wire logic [9:0]           i_ext_irq,
  input  wire logic                 i_rtc_alarm,
  input  wire logic                 i_modem_irq,
  // PLL macro control
  output pcg_pll_drive_t            o_main_pll,
  output pcg_pll_drive_t            o_aux_pll,
  output logic                      o_main_pll_locked,
  output logic                      o_aux_pll_locked,
  // Clock gating and power modes
  output logic      [31:0]          o_block_clk_en,
  output logic                      o_bus_clk_mon_en,
  output logic                      o_cpu_clk_en,
  output logic                      o_idle_mode,
  output logic                      o_stop_mode
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0]    pll_cfg_reg [PCG_PLL_NUM];
  logic [15:0]    lock_cnt_reg [PCG_PLL_NUM];
  logic [PCG_PLL_NUM-1:0] locked_reg;
  logic [PCG_PLL_NUM-1:0] restart;
  logic [PCG_PLL_NUM-1:0] wr_pll;
  pcg_pll_drive_t drive_reg [PCG_PLL_NUM];
  logic [31:0]    gate_reg;
  logic [31:0]    lock_time_reg;
  logic [31:0]    clk_en_reg;
  logic [31:0]    prdata_reg;
  logic [31:0]    rd_next;
  logic           rd_err_next;
  logic           pready_reg;
  logic           pslverr_reg;
  logic           cpu_en_reg;
  logic           idle_reg;
  logic           stop_reg;
  logic [2:0]     ref_sync_reg;
  logic           ref_lvl_reg;
  logic [2:0]     warm_sync_reg;
  logic           warm_lvl_reg;
  logic           wr_cycle;
  logic           wr_gate;
  logic           wr_lock;
  logic           ref_rise;
  logic           warm_active;
  logic           stop_wake;
  logic           stop_exit;
  logic [31:0]    src_ok;

  // ************************************************************
  // APB slave
  // ************************************************************

  // A write lands only at the access edge where pready is already high.
  assign wr_cycle  = i_psel & i_penable & i_pwrite & pready_reg;
  assign wr_gate   = wr_cycle & (i_paddr == PCG_GATE_ADDR);
  assign wr_lock   = wr_cycle & (i_paddr == PCG_LOCK_TIME_ADDR);
  assign wr_pll[PCG_PLL_MAIN] = wr_cycle & (i_paddr == PCG_MAIN_PLL_ADDR);
  assign wr_pll[PCG_PLL_AUX]  = wr_cycle & (i_paddr == PCG_AUX_PLL_ADDR);

  // Unmapped addresses fall to the default and answer with zero data and an error.
  // Read data is chosen in the setup cycle so that every bus output is a flop.
  always_comb
  begin
    rd_next     = 32'h0000_0000;
    rd_err_next = 1'b0;
    unique case (i_paddr)
      PCG_LOCK_TIME_ADDR: rd_next = lock_time_reg;
      PCG_MAIN_PLL_ADDR:  rd_next = pll_cfg_reg[PCG_PLL_MAIN];
      PCG_AUX_PLL_ADDR:   rd_next = pll_cfg_reg[PCG_PLL_AUX];
      PCG_GATE_ADDR:      rd_next = gate_reg;
      PCG_STATUS_ADDR:    rd_next = {28'h000_0000, stop_reg, idle_reg, locked_reg};
      default:            rd_err_next = 1'b1;
    endcase
  end

  // One access cycle per transfer; unmapped addresses answer with an error.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= i_psel & ~i_penable;
      if (i_psel && !i_penable)
      begin
        pslverr_reg <= rd_err_next;
        prdata_reg  <= i_pwrite ? 32'h0000_0000 : rd_next;
      end
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************

  // The lock time word is writable so software can shorten a relock before a change.
  // Reserved gate bits are forced low on write; the reset pattern is kept as is.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      gate_reg      <= PCG_GATE_RST;                              // see R6
      lock_time_reg <= PCG_LOCK_TIME_RST;
    end
    else
    begin
      if (wr_gate)
      begin
        gate_reg <= i_pwdata & PCG_GATE_WR_MASK;                  // see R10
      end
      if (wr_lock)
      begin
        lock_time_reg <= i_pwdata & PCG_LOCK_WR_MASK;
      end
    end
  end

  // ************************************************************
  // Reference clock and warm reset pin synchronisers
  // ************************************************************

  // The warm stages reset to the inactive level so no false wake follows reset.
  // A level counts once the second and third stages agree, filtering a runt.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ref_sync_reg  <= 3'h0;
      ref_lvl_reg   <= 1'b0;
      warm_sync_reg <= 3'h7;
      warm_lvl_reg  <= 1'b1;
    end
    else
    begin
      ref_sync_reg  <= {ref_sync_reg[1:0], i_ref_clk};
      warm_sync_reg <= {warm_sync_reg[1:0], i_warm_reset_pin_n};
      if (ref_sync_reg[1] == ref_sync_reg[2])
      begin
        ref_lvl_reg <= ref_sync_reg[2];
      end
      if (warm_sync_reg[1] == warm_sync_reg[2])
      begin
        warm_lvl_reg <= warm_sync_reg[2];
      end
    end
  end

  // A reference edge becomes a one-cycle enable; the counters never see the pin.
  // The reference must run well below half the core rate, or edges are lost.
  assign ref_rise    = (ref_sync_reg[1] == ref_sync_reg[2]) & ref_sync_reg[2] & ~ref_lvl_reg;
  assign warm_active = ~warm_lvl_reg;

  // ************************************************************
  // Power modes
  // ************************************************************

  // The external, RTC alarm and modem interrupts and the warm reset pin leave STOP.
  assign stop_wake = (|i_ext_irq) | i_rtc_alarm | i_modem_irq | warm_active; // see R14
  assign stop_exit = stop_reg & stop_wake & ~(wr_gate & i_pwdata[PCG_STOP_BIT]);

  // The gate register keeps the mode bits as written; these flags hold the live state.
  // Software must clear the written mode bits itself, since hardware never does.
  // Entry writes win over a wake in the same cycle so an entry is never lost.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
    end
    else
    begin
      if (wr_gate && i_pwdata[PCG_IDLE_BIT])
      begin
        idle_reg <= 1'b1;                                         // see R10
      end
      else if (i_irq_any || warm_active)
      begin
        idle_reg <= 1'b0;                                         // see R13
      end
      if (wr_gate && i_pwdata[PCG_STOP_BIT])
      begin
        stop_reg <= 1'b1;                                         // see R11
      end
      else if (stop_wake)
      begin
        stop_reg <= 1'b0;                                         // see R14
      end
    end
  end

  // ************************************************************
  // PLL configuration and lock timing, one slice per PLL
  // ************************************************************
  generate
    for (genvar g = 0; g < PCG_PLL_NUM; g++)
    begin : g_pll
      // Each slice picks its lock field and reset pattern from the PLL index.
      localparam int LOCK_LSB = (g == PCG_PLL_MAIN) ? PCG_LOCK_MAIN_LSB : PCG_LOCK_AUX_LSB;
      localparam logic [31:0] CFG_RST = (g == PCG_PLL_MAIN) ? PCG_MAIN_PLL_RST
                                                            : PCG_AUX_PLL_RST;

      // Rewriting the same value leaves the clocks running, so a refresh costs nothing.
      // Only a write that really alters a divider, or a STOP wake, relocks.
      assign restart[g] = (wr_pll[g] &&
                           ((i_pwdata & PCG_PLL_WR_MASK) != pll_cfg_reg[g])) ||
                          stop_exit;                              // see R16

      // Divider fields keep their positions; unused bits stay zero.
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          pll_cfg_reg[g] <= CFG_RST;                              // see R4
        end
        else if (wr_pll[g])
        begin
          pll_cfg_reg[g] <= i_pwdata & PCG_PLL_WR_MASK;           // see R3
        end
      end

      // The macro sees the effective m, p and s, so its output is m*Fin/(p*2^s).
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          drive_reg[g] <= '0;
        end
        else
        begin
          drive_reg[g].m <= {1'b0, pll_cfg_reg[g][PCG_MAIN_DIVIDER_LSB +: 8]} + PCG_M_OFFSET; // see R1
          drive_reg[g].p <= {1'b0, pll_cfg_reg[g][PCG_PRE_DIVIDER_LSB +: 6]} + PCG_P_OFFSET; // see R1
          drive_reg[g].s <= pll_cfg_reg[g][PCG_POST_DIVIDER_LSB +: 2];                        // see R1
        end
      end

      // A zero lock field still waits for one reference edge before lock.
      // Counts reference edges; frozen in STOP since the PLL is off then.
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          lock_cnt_reg[g] <= PCG_LOCK_CNT_RST;
          locked_reg[g]   <= 1'b0;
        end
        else if (restart[g])
        begin
          lock_cnt_reg[g] <= {lock_time_reg[LOCK_LSB +: PCG_LOCK_W], 4'h0}; // see R15
          locked_reg[g]   <= 1'b0;
        end
        else if (!locked_reg[g] && ref_rise && !stop_reg)
        begin
          if (lock_cnt_reg[g] <= 16'h0001)
          begin
            lock_cnt_reg[g] <= 16'h0000;
            locked_reg[g]   <= 1'b1;                              // see R15
          end
          else
          begin
            lock_cnt_reg[g] <= lock_cnt_reg[g] - 16'h0001;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Clock gate outputs
  // ************************************************************

  // Until its own PLL locks after reset each block clock stays off, which is intended.
  // Camera core and infrared run from the aux PLL, all others from the main.
  assign src_ok = (PCG_AUX_SRC_MASK & {32{locked_reg[PCG_PLL_AUX]}}) |
                  (~PCG_AUX_SRC_MASK & {32{locked_reg[PCG_PLL_MAIN]}});  // see R8

  // The mode bits are masked out here so they never reach a block enable.
  // Gating is registered so an enable changes only on a clean clock edge.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clk_en_reg <= 32'h0000_0000;
      cpu_en_reg <= 1'b0;
    end
    else
    begin
      clk_en_reg <= gate_reg & ~PCG_MODE_BITS & src_ok & {32{~stop_reg}}; // see R7
      cpu_en_reg <= ~idle_reg & ~stop_reg & locked_reg[PCG_PLL_MAIN];   // see R13
    end
  end

  // Outputs are plain copies of flops, so no logic sits between a flop and a pin.
  // Each gate bit above the three mode bits maps to its block enable at the same position.
  assign o_block_clk_en    = clk_en_reg;                          // see R9
  assign o_bus_clk_mon_en  = gate_reg[PCG_MON_BIT];               // see R12
  assign o_cpu_clk_en      = cpu_en_reg;
  assign o_idle_mode       = idle_reg;
  assign o_stop_mode       = stop_reg;
  assign o_main_pll        = drive_reg[PCG_PLL_MAIN];
  assign o_aux_pll         = drive_reg[PCG_PLL_AUX];
  assign o_main_pll_locked = locked_reg[PCG_PLL_MAIN];
  assign o_aux_pll_locked  = locked_reg[PCG_PLL_AUX];
  assign o_prdata          = prdata_reg;
  assign o_pready          = pready_reg;
  assign o_pslverr         = pslverr_reg;

endmodule : pcg_top

/* pcg_pkg.sv */
// Constants and carrier types of the PLL configuration and clock gating block.
package pcg_pkg;

  // ************************************************************
  // Register map and reset values
  // ************************************************************
  localparam logic [31:0] PCG_LOCK_TIME_ADDR = 32'h4000_0000;
  localparam logic [31:0] PCG_MAIN_PLL_ADDR  = 32'h4000_0010;
  localparam logic [31:0] PCG_AUX_PLL_ADDR   = 32'h4000_0014;
  localparam logic [31:0] PCG_GATE_ADDR      = 32'h4000_0020;
  localparam logic [31:0] PCG_STATUS_ADDR    = 32'h4000_0040;
  localparam logic [31:0] PCG_MAIN_PLL_RST   = 32'h0004_8021;
  localparam logic [31:0] PCG_AUX_PLL_RST    = 32'h0003_0021;
  localparam logic [31:0] PCG_GATE_RST       = 32'h03FF_FFF0;
  localparam logic [31:0] PCG_LOCK_TIME_RST  = 32'h0FFF_0FFF;
  localparam logic [31:0] PCG_PLL_WR_MASK    = 32'h000F_F3F3;
  localparam logic [31:0] PCG_GATE_WR_MASK   = 32'h37FF_FFD7;
  localparam logic [31:0] PCG_LOCK_WR_MASK   = 32'h0FFF_0FFF;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PCG_PLL_NUM      = 2;
  localparam int PCG_PLL_MAIN     = 0;
  localparam int PCG_PLL_AUX      = 1;
  localparam int PCG_MAIN_DIVIDER_LSB     = 12;
  localparam int PCG_PRE_DIVIDER_LSB     = 4;
  localparam int PCG_POST_DIVIDER_LSB     = 0;
  localparam int PCG_LOCK_MAIN_LSB = 0;
  localparam int PCG_LOCK_AUX_LSB = 16;
  localparam int PCG_LOCK_W       = 12;
  localparam int PCG_STOP_BIT     = 0;
  localparam int PCG_MON_BIT      = 1;
  localparam int PCG_IDLE_BIT     = 2;
  localparam int PCG_INFRARED_BIT = 4;
  localparam int PCG_CAMERA_CORE_BIT = 23;
  localparam logic [31:0] PCG_MODE_BITS = 32'h0000_0007;
  localparam logic [31:0] PCG_AUX_SRC_MASK =
    (32'h1 << PCG_CAMERA_CORE_BIT) | (32'h1 << PCG_INFRARED_BIT);

  // ************************************************************
  // Divider offsets and lock timing
  // ************************************************************
  localparam logic [8:0]  PCG_M_OFFSET     = 9'h008;
  localparam logic [6:0]  PCG_P_OFFSET     = 7'h02;
  localparam logic [15:0] PCG_LOCK_CNT_RST = 16'hFFF0;

  // Effective divider values presented to the analog PLL macro.
  typedef struct packed {
    logic [8:0] m;
    logic [6:0] p;
    logic [1:0] s;
  } pcg_pll_drive_t;

endpackage : pcg_pkg

/* pcg_asserts.sv */
// Port-level assertions for the PLL configuration and clock gating block.
`timescale 1ns/1ps
module pcg_asserts
  import pcg_pkg::*;
(
  // Clock, reset and APB
  input wire logic           i_clk,
  input wire logic           i_arst_n,
  input wire logic           i_psel,
  input wire logic           i_penable,
  input wire logic           i_pwrite,
  input wire logic [31:0]    i_paddr,
  input wire logic [31:0]    i_pwdata,
  input wire logic           o_pready,
  // Wake sources
  input wire logic           i_warm_reset_pin_n,
  input wire logic           i_irq_any,
  input wire logic [9:0]     i_ext_irq,
  input wire logic           i_rtc_alarm,
  input wire logic           i_modem_irq,
  // Clock control outputs
  input wire pcg_pll_drive_t o_main_pll,
  input wire logic           o_main_pll_locked,
  input wire logic [31:0]    o_block_clk_en,
  input wire logic           o_bus_clk_mon_en,
  input wire logic           o_cpu_clk_en,
  input wire logic           o_idle_mode,
  input wire logic           o_stop_mode
);
  // A write counts only at the edge where pready is seen with it.
  logic wr_done, wr_main, wr_gate, stop_wake;
  assign wr_done   = i_psel && i_penable && o_pready && i_pwrite;
  assign wr_main   = wr_done && (i_paddr == PCG_MAIN_PLL_ADDR);
  assign wr_gate   = wr_done && (i_paddr == PCG_GATE_ADDR);
  assign stop_wake = (|i_ext_irq) || i_rtc_alarm || i_modem_irq;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // Drive and block enables settle two edges after the write lands: register, then output stage; monitor enable after one.
  AST_MAIN_DRIVE: assert property (wr_main |-> ##2
    (o_main_pll.m == 9'($past(i_pwdata[19:12], 2)) + 9'h008) &&
    (o_main_pll.p == 7'($past(i_pwdata[9:4], 2)) + 7'h02) &&
    (o_main_pll.s == $past(i_pwdata[1:0], 2)))
    else $error("Main PLL drive wrong.");
  AST_GATE_MASK: assert property (wr_gate |-> ##2
    ((o_block_clk_en & ~$past(i_pwdata, 2)) == 32'h0000_0000))
    else $error("Cleared gate bit still enables.");
  AST_MON: assert property (wr_gate |-> ##2
    (o_bus_clk_mon_en == $past(i_pwdata[1], 2)))
    else $error("Monitor enable wrong.");
  AST_MODE_BITS: assert property ((o_block_clk_en & 32'h0000_0007) == 32'h0)
    else $error("Mode bit seen as clock.");
  AST_STOP_GATES: assert property (o_stop_mode [*2] |-> (o_block_clk_en == 32'h0))
    else $error("Clock enabled in STOP.");
  AST_IDLE_CPU: assert property (o_idle_mode |=> !o_cpu_clk_en)
    else $error("CPU clock in IDLE.");
  // Warm reset travels a synchroniser, so it must stay quiet for a while first.
  AST_STOP_HOLD: assert property ((i_warm_reset_pin_n [*6] ##0
    (o_stop_mode && !stop_wake)) |=> o_stop_mode)
    else $error("STOP left without wake.");
  AST_STOP_WAKE: assert property ((o_stop_mode && stop_wake && !i_psel) |=> !o_stop_mode)
    else $error("STOP kept after wake.");
  AST_IDLE_WAKE: assert property ((o_idle_mode && i_irq_any && !i_psel &&
    !$past(i_psel)) |=> !o_idle_mode)
    else $error("IDLE kept after interrupt.");
  AST_LOCK_GATE: assert property (!o_main_pll_locked |=>
    ((o_block_clk_en & 32'hFF7F_FFEF) == 32'h0))
    else $error("Clock passed before lock.");
endmodule : pcg_asserts

bind pcg_top pcg_asserts u_asserts (.*);

/* pcg_peer.sv */
// Far-side model: reference oscillator and one gated peripheral.
`timescale 1ns/1ps
module pcg_peer
#(
  parameter int HALF_NS = 21
)
(
  // Core clock and block enables
  input  wire logic        i_clk,
  input  wire logic [31:0] i_block_clk_en,
  // Reference pin and peripheral activity
  output logic             o_ref_clk,
  output logic [15:0]      o_uart_ticks
);
  // Free-running crystal, unrelated in phase to the core clock.
  initial
  begin
    o_ref_clk = 1'b0;
    forever #(HALF_NS) o_ref_clk = ~o_ref_clk;
  end
  // The UART only sees edges while its enable is high; one process owns the count.
  initial
  begin
    o_uart_ticks = 16'h0000;
    forever
    begin
      @(posedge i_clk);
      if (i_block_clk_en[9])
        o_uart_ticks <= o_uart_ticks + 16'h0001;
    end
  end
endmodule : pcg_peer

/* test_pcg_top.sv */
// Self-checking testbench of the PLL configuration and clock gating block.
`timescale 1ns/1ps
module test_pcg_top
  import pcg_pkg::*;
;
  logic        clk, arst_n, psel, penable, pwrite, warm_n, irq_any, rtc, modem;
  logic        ref_clk, pready, pslverr, mlock, alock, mon, cpu, idle, stop, e_rd;
  logic [9:0]  ext_irq;
  logic [15:0] ticks, t0;
  logic [31:0] paddr, pwdata, prdata, blk_en, q_rd, v, g;
  pcg_pll_drive_t mpll, apll;
  int          seed = 32'h18E8;
  int          err_total = 0;
  int          checks_done = 0;
  logic [31:0] ra [4] = '{PCG_MAIN_PLL_ADDR, PCG_AUX_PLL_ADDR, PCG_GATE_ADDR, 32'h4000_0008};
  logic [31:0] rv [4] = '{32'h0004_8021, 32'h0003_0021, 32'h03FF_FFF0, 32'h0};

  // The design and its far side.
  pcg_top dut (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ref_clk(ref_clk),
    .i_warm_reset_pin_n(warm_n), .i_irq_any(irq_any), .i_ext_irq(ext_irq),
    .i_rtc_alarm(rtc), .i_modem_irq(modem), .o_main_pll(mpll), .o_aux_pll(apll),
    .o_main_pll_locked(mlock), .o_aux_pll_locked(alock), .o_block_clk_en(blk_en),
    .o_bus_clk_mon_en(mon), .o_cpu_clk_en(cpu), .o_idle_mode(idle), .o_stop_mode(stop));
  pcg_peer peer (.i_clk(clk), .i_block_clk_en(blk_en), .o_ref_clk(ref_clk),
    .o_uart_ticks(ticks));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out;
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // The request stands until pready is seen high at a rising edge; data is taken there.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q_rd = prdata;
    e_rd = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick

  task automatic wait_lock;
    int n;
    n = 0;
    while ({mlock, alock} !== 2'b11 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    tick(1);
    chk({30'h0, mlock, alock}, 32'h3);
  endtask : wait_lock

  function automatic logic [31:0] drv(input logic [31:0] x);
    return {14'h0, 9'(x[19:12]) + 9'h008, 7'(x[9:4]) + 7'h02, x[1:0]};
  endfunction : drv

  // Core clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cuts a hang short; the full run needs under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {psel, penable, pwrite, irq_any, rtc, modem, ext_irq, paddr, pwdata} = '0;
    warm_n = 1'b1;
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(q_rd, rv[i]);
      chk({31'h0, e_rd}, {31'h0, 1'(i == 3)});
    end
    chk({14'h0, mpll}, drv(32'h0004_8021));
    chk({14'h0, apll}, drv(32'h0003_0021));
    // A short lock count keeps each relock brief.
    apb(1'b1, PCG_LOCK_TIME_ADDR, 32'h0001_0001);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      v[19:12] = 8'(5 + 16 * i) + 8'(v[3:0]);
      if (i == 0)
        v = 32'h0002_A010;
      apb(1'b1, PCG_MAIN_PLL_ADDR, v);
      apb(1'b1, PCG_AUX_PLL_ADDR, v);
      tick(0);
      chk(blk_en & 32'hFF7F_FFEF, 32'h0);
      wait_lock();
      chk(blk_en, 32'h03FF_FFF0);
      apb(1'b0, PCG_MAIN_PLL_ADDR, 32'h0);
      chk(q_rd, v & 32'h000F_F3F3);
      chk({14'h0, mpll}, drv(v));
      chk({14'h0, apll}, drv(v));
    end
    for (int j = 0; j < 4; j++)
    begin
      g = 32'hFFFF_FFFA & ((j == 0) ? 32'h0 : (j == 1) ? 32'hFFFF_FFFF : $random(seed));
      apb(1'b1, PCG_GATE_ADDR, g);
      tick(2);
      t0 = ticks;
      chk(blk_en, g & 32'h37FF_FFD0);
      chk({31'h0, mon}, {31'h0, g[1]});
      tick(10);
      chk({16'h0, 16'(ticks - t0)}, g[9] ? 32'h0000_000A : 32'h0);
      apb(1'b0, PCG_GATE_ADDR, 32'h0);
      chk(q_rd, g & 32'h37FF_FFD7);
    end
    // IDLE ends on an interrupt, then on the warm reset pin.
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, PCG_GATE_ADDR, 32'h03FF_FFD4);
      tick(2);
      chk({30'h0, idle, cpu}, 32'h2);
      @(posedge clk);
      {irq_any, warm_n} <= (k == 0) ? 2'b11 : 2'b00;
      // Two cycles low, so the warm pin's second and third stages can agree.
      repeat (2) @(posedge clk);
      {irq_any, warm_n} <= 2'b01;
      tick(6);
      chk({31'h0, idle}, 32'h0);
    end
    apb(1'b0, PCG_GATE_ADDR, 32'h0);
    chk(q_rd, 32'h03FF_FFD4);
    // STOP ignores a plain interrupt and ends on an external, the RTC alarm and the modem interrupt.
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, PCG_GATE_ADDR, 32'h03FF_FFD1);
      @(posedge clk);
      irq_any <= 1'b1;
      @(posedge clk);
      irq_any <= 1'b0;
      tick(2);
      chk({31'h0, stop}, 32'h1);
      chk(blk_en, 32'h0);
      @(posedge clk);
      {modem, rtc, ext_irq} <= 12'h1 << ((k == 0) ? $unsigned($random(seed)) % 10 : 9 + k);
      @(posedge clk);
      {modem, rtc, ext_irq} <= 12'h0;
      tick(2);
      chk({31'h0, stop}, 32'h0);
      wait_lock();
      apb(1'b0, PCG_STATUS_ADDR, 32'h0);
      chk(q_rd, 32'h3);
    end
    apb(1'b0, PCG_GATE_ADDR, 32'h0);
    chk(q_rd, 32'h03FF_FFD1);
    // A second reset in mid-run restores the defaults.
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, PCG_GATE_ADDR, 32'h0);
    chk(q_rd, 32'h03FF_FFF0);
    chk({14'h0, mpll}, drv(32'h0004_8021));
    chk({29'h0, stop, idle, cpu}, 32'h0);
    apb(1'b0, PCG_LOCK_TIME_ADDR, 32'h0);
    chk(q_rd, 32'h0FFF_0FFF);
    close_out();
  end
endmodule : test_pcg_top
